// [rtl/audio_data_service.v]
// Data service path of a multichannel audio serial port: buffers,
// ready flags, DMA requests, data-port sequencing and transmit format.
// Assumes a register master on clk and link pins from another domain.
//
// Function
// RL1: Receive ready sets when shift registers move into buffers.
// RL2: Receive ready clears on write-one or when all receivers read.
// RL3: Each receive ready setting issues a receive DMA request.
// RL4: Receive interrupt follows ready flag when ready-interrupt enable is on.
// RL5: Every transfer raises a new DMA request, even with flag set.
// RL6: One receive DMA request per slot covers all receivers.
// RL7: Receive DMA request visible within five clocks of last bit.
// RL8: Software clears bus-select bits before using the data port.
// RL9: Software sets bus-select bits before using per-serializer addresses.
// RL10: Data port is one address stepping through active serializers.
// RL11: Data-port writes go to transmitters in ascending index order.
// RL12: Data-port reads return receivers in ascending index order.
// RL13: An unwritten transmitter at slot load is an underrun.
// RL14: An unread receiver at slot transfer is an overrun.
// RL15: Each serializer buffer decodes at its own per-serializer address.
// RL16: Slot size field gives 8 to 32 bits in steps of four.
// RL17: Transmit word rotates right by 0 to 28 in fours.
// RL18: Bit-reverse set reverses the word; clear passes it unchanged.
// RL19: Masked bits take a chosen bit copy, zero or one.
// RL20: Mask and pad run first, on the word as written.
// RL21: Software derives rotation from order, alignment and representation.
// RL22: I2S streams use MSB-first, left-aligned, one-bit data delay.
// RL23: Transmit ready sets on load, clears on write-one or all written.
// RL24: Underrun checked per slot, sticky until written with one.
// RL25: Data-port pointer restarts at lowest active serializer each event.
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_defs.vh"

module audio_data_service #(
   parameter NSER = 4
) (
   input  wire            clk,
   input  wire            resetn,
   input  wire [7:0]      addr,
   input  wire [31:0]     wdata,
   input  wire            wr_en,
   input  wire            rd_en,
   output reg  [31:0]     rdata,
   input  wire            bit_clock,
   input  wire            frame_sync,
   input  wire [NSER-1:0] ser_data_in,
   output wire [NSER-1:0] ser_data_out,
   output wire [NSER-1:0] ser_data_oe,
   output reg             tx_dma_request,
   output reg             rx_dma_request,
   output wire            tx_irq,
   output wire            rx_irq
);

   // Five bits cover up to sixteen serializers plus the none code
   localparam PW = 5;
   localparam [PW-1:0] NONE = NSER[PW-1:0];

   reg [2*NSER-1:0]       ser_mode_reg;
   reg [`TX_FMT_W-1:0]    tx_format_reg;
   reg                    rx_format_reg;
   reg [31:0]             tx_mask_reg;
   reg                    tx_ready_flag;
   reg                    tx_underrun_flag;
   reg                    rx_ready_reg;
   reg                    rx_overrun_reg;
   reg [1:0]              tx_irq_control;
   reg [1:0]              rx_irq_control;
   reg [PW-1:0]           tx_ptr_reg;
   reg [PW-1:0]           rx_ptr_reg;
   reg                    frame_seen_reg;
   reg                    running_reg;
   reg [1:0]              delay_reg;
   reg [4:0]              bit_cnt_reg;
   reg [31:0]             rdata_next;

   wire [NSER+1:0]        sync_level;
   wire [NSER+1:0]        sync_rise;
   wire [NSER-1:0]        din;
   wire                   bit_edge;
   wire                   frame_edge;
   wire [NSER-1:0]        is_tx;
   wire [NSER-1:0]        is_rx;
   wire [NSER-1:0]        buf_wr;
   wire [NSER-1:0]        buf_rd;
   wire [NSER-1:0]        written;
   wire [NSER-1:0]        unread;
   wire [32*NSER-1:0]     buffer_flat;
   wire                   tx_bus_select;
   wire                   rx_bus_select;
   wire [2:0]             tx_slot_size;
   wire [1:0]             tx_data_delay;
   wire [5:0]             slot_last;
   wire                   bit_step;
   wire                   slot_end;
   wire                   cfg_hit;
   wire [PW-1:0]          cfg_idx;
   wire                   dp_hit;
   wire                   dp_wr;
   wire                   dp_rd;
   wire                   cfg_wr;
   wire                   cfg_rd;
   wire [PW-1:0]          tx_sel;
   wire [PW-1:0]          rx_sel;
   wire                   underrun_now;
   wire                   overrun_now;
   wire                   all_tx_written;
   wire                   all_rx_read;

   // Lowest active serializer at or above start, or NONE
   function [PW-1:0] next_active;
      input [NSER-1:0] m;
      input [PW-1:0]   start;
      integer          k;
      begin
         next_active = NONE;
         for (k = NSER - 1; k >= 0; k = k - 1) begin
            if (m[k] && (k >= start)) begin
               next_active = k[PW-1:0];
            end
         end
      end
   endfunction

   // Link pins cross into clk through two flops before any use
   link_sync #(
      .W (NSER + 2)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .pin_in ({frame_sync, bit_clock, ser_data_in}),
      .level  (sync_level),
      .rise   (sync_rise)
   );

   assign din        = sync_level[NSER-1:0];
   assign bit_edge   = sync_rise[NSER];
   assign frame_edge = sync_rise[NSER+1];

   // Format fields
   assign tx_bus_select = tx_format_reg[`FMT_BUSSEL];
   assign rx_bus_select = rx_format_reg;
   assign tx_slot_size  = tx_format_reg[`FMT_SSZ_LSB+2:`FMT_SSZ_LSB];
   assign tx_data_delay = tx_format_reg[`FMT_DLY_LSB+1:`FMT_DLY_LSB];

   // Slot of 8 + 4n bits; codes above the top step give 32 bits
   assign slot_last = (tx_slot_size > `SSZ_MAX_CODE) ? `SLOT_MAX_LAST :
                      (`SLOT_BASE_LAST + {1'b0, tx_slot_size, 2'b00}); // [RL16]

   // A bit counts once the frame has started and the delay is spent
   assign bit_step = bit_edge & running_reg & (delay_reg == 2'h0);
   assign slot_end = bit_step & ({1'b0, bit_cnt_reg} == slot_last);

   // Address decode for the data port and per-serializer window
   assign dp_hit  = (addr == `OFS_DATA_PORT);
   assign cfg_hit = (addr[7:6] == `SER_BUF_WIN);
   assign cfg_idx = {1'b0, addr[5:2]};
   assign dp_wr   = wr_en & dp_hit & ~tx_bus_select;
   assign dp_rd   = rd_en & dp_hit & ~rx_bus_select;
   assign cfg_wr  = wr_en & cfg_hit & tx_bus_select;
   assign cfg_rd  = rd_en & cfg_hit & rx_bus_select;
   assign tx_sel  = next_active(is_tx, tx_ptr_reg);  // [RL11]
   assign rx_sel  = next_active(is_rx, rx_ptr_reg);  // [RL12]

   // Per-serializer buffer, shift register and service tracking
   genvar i;
   generate
      for (i = 0; i < NSER; i = i + 1) begin : g_ser
         localparam [PW-1:0] IDX = i;
         reg  [31:0] serializer_buffer;
         reg  [31:0] serializer_shift_reg;
         reg         written_reg;
         reg         unread_reg;
         wire [31:0] fmt_word;

         assign is_tx[i] = (ser_mode_reg[2*i+1:2*i] == `MODE_TX);
         assign is_rx[i] = (ser_mode_reg[2*i+1:2*i] == `MODE_RX);
         assign buf_wr[i] = is_tx[i] & ((dp_wr & (tx_sel == IDX)) |
                                        (cfg_wr & (cfg_idx == IDX)));  // [RL10] [RL15]
         assign buf_rd[i] = is_rx[i] & ((dp_rd & (rx_sel == IDX)) |
                                        (cfg_rd & (cfg_idx == IDX)));  // [RL10] [RL15]
         assign written[i] = written_reg;
         assign unread[i]  = unread_reg;
         assign buffer_flat[32*i+31:32*i] = serializer_buffer;
         assign ser_data_out[i] = serializer_shift_reg[0];
         assign ser_data_oe[i]  = is_tx[i];

         tx_formatter u_fmt (
            .word      (serializer_buffer),
            .mask      (tx_mask_reg),
            .pad_mode  (tx_format_reg[`FMT_PAD_LSB+1:`FMT_PAD_LSB]),
            .pad_bit   (tx_format_reg[`FMT_PADBIT_LSB+4:`FMT_PADBIT_LSB]),
            .rotate    (tx_format_reg[`FMT_ROT_LSB+2:`FMT_ROT_LSB]),
            .reverse   (tx_format_reg[`FMT_REV]),
            .formatted (fmt_word)
         );

         // Transmit shifts out bit 0 first; receive shifts in at bit 0
         always @(posedge clk) begin
            if (!resetn) begin
               serializer_buffer    <= 32'h00000000;
               serializer_shift_reg <= 32'h00000000;
               written_reg          <= 1'b0;
               unread_reg           <= 1'b0;
            end else begin
               if (bit_step) begin
                  if (slot_end) begin
                     serializer_shift_reg <= is_tx[i] ? fmt_word : 32'h00000000;
                  end else if (is_tx[i]) begin
                     serializer_shift_reg <= {1'b0, serializer_shift_reg[31:1]};
                  end else begin
                     serializer_shift_reg <= {serializer_shift_reg[30:0], din[i]};
                  end
               end
               if (buf_wr[i]) begin
                  serializer_buffer <= wdata;
               end else if (slot_end && is_rx[i]) begin
                  serializer_buffer <= {serializer_shift_reg[30:0], din[i]}; // [RL1]
               end
               // A write in the load cycle counts for the next slot
               if (buf_wr[i]) begin
                  written_reg <= 1'b1;
               end else if (slot_end) begin
                  written_reg <= 1'b0;
               end
               // New data wins over a read in the same cycle
               if (slot_end && is_rx[i]) begin
                  unread_reg <= 1'b1;
               end else if (buf_rd[i]) begin
                  unread_reg <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Errors are judged against the state before this slot's transfer
   assign underrun_now   = slot_end & |(is_tx & ~written);   // [RL13]
   assign overrun_now    = slot_end & |(is_rx & unread);     // [RL14]
   assign all_tx_written = ((written & is_tx) == is_tx);
   assign all_rx_read    = ((unread & is_rx) == {NSER{1'b0}});

   // Frame start, data delay and bit counting inside the slot
   always @(posedge clk) begin
      if (!resetn) begin
         frame_seen_reg <= 1'b0;
         running_reg    <= 1'b0;
         delay_reg      <= 2'h0;
         bit_cnt_reg    <= 5'h00;
      end else begin
         if (frame_edge) begin
            frame_seen_reg <= 1'b1;
         end else if (bit_edge) begin
            frame_seen_reg <= 1'b0;
         end
         if (bit_edge && frame_seen_reg && !running_reg) begin
            running_reg <= 1'b1;
            delay_reg   <= tx_data_delay;  // [RL22]
            bit_cnt_reg <= 5'h00;
         end else if (bit_edge && running_reg && delay_reg != 2'h0) begin
            delay_reg <= delay_reg - 2'h1;
         end else if (slot_end) begin
            bit_cnt_reg <= 5'h00;
         end else if (bit_step) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // One request per slot for all serializers, whatever the flag holds
   always @(posedge clk) begin
      if (!resetn) begin
         tx_dma_request <= 1'b0;
         rx_dma_request <= 1'b0;
      end else begin
         tx_dma_request <= slot_end & |is_tx;  // [RL23] [RL5]
         rx_dma_request <= slot_end & |is_rx;  // [RL3] [RL5] [RL6] [RL7]
      end
   end

   // Data-port pointers restart at each ready event, then step upward
   always @(posedge clk) begin
      if (!resetn) begin
         tx_ptr_reg <= {PW{1'b0}};
         rx_ptr_reg <= {PW{1'b0}};
      end else begin
         if (slot_end) begin
            tx_ptr_reg <= {PW{1'b0}};  // [RL25]
            rx_ptr_reg <= {PW{1'b0}};  // [RL25]
         end else begin
            if (dp_wr && tx_sel != NONE) begin
               tx_ptr_reg <= tx_sel + 5'h01;  // [RL11]
            end
            if (dp_rd && rx_sel != NONE) begin
               rx_ptr_reg <= rx_sel + 5'h01;  // [RL12]
            end
         end
      end
   end

   // Control registers and status flags; hardware set wins over clear
   always @(posedge clk) begin
      if (!resetn) begin
         ser_mode_reg     <= {2*NSER{1'b0}};
         tx_format_reg    <= `RESET_TX_FMT;
         rx_format_reg    <= 1'b0;
         tx_mask_reg      <= `RESET_MASK;
         tx_irq_control   <= 2'h0;
         rx_irq_control   <= 2'h0;
         tx_ready_flag    <= 1'b0;
         tx_underrun_flag <= 1'b0;
         rx_ready_reg     <= 1'b0;
         rx_overrun_reg   <= 1'b0;
      end else begin
         if (wr_en) begin
            case (addr)
               `OFS_SER_MODE:  ser_mode_reg   <= wdata[2*NSER-1:0];
               `OFS_TX_FMT:    tx_format_reg  <= wdata[`TX_FMT_W-1:0];
               `OFS_RX_FMT:    rx_format_reg  <= wdata[`FMT_BUSSEL];
               `OFS_TX_MASK:   tx_mask_reg    <= wdata;
               `OFS_TX_IRQCTL: tx_irq_control <= wdata[1:0];
               `OFS_RX_IRQCTL: rx_irq_control <= wdata[1:0];
               default: ;
            endcase
         end
         // Transmit ready
         if (slot_end && |is_tx) begin
            tx_ready_flag <= 1'b1;  // [RL23]
         end else if ((wr_en && addr == `OFS_TX_STAT && wdata[`STAT_READY]) ||
                      all_tx_written) begin
            tx_ready_flag <= 1'b0;  // [RL23]
         end
         // Underrun stays until software writes a one
         if (underrun_now) begin
            tx_underrun_flag <= 1'b1;  // [RL24]
         end else if (wr_en && addr == `OFS_TX_STAT && wdata[`STAT_ERR]) begin
            tx_underrun_flag <= 1'b0;  // [RL24]
         end
         // Receive ready
         if (slot_end && |is_rx) begin
            rx_ready_reg <= 1'b1;  // [RL1]
         end else if ((wr_en && addr == `OFS_RX_STAT && wdata[`STAT_READY]) ||
                      all_rx_read) begin
            rx_ready_reg <= 1'b0;  // [RL2]
         end
         if (overrun_now) begin
            rx_overrun_reg <= 1'b1;  // [RL14]
         end else if (wr_en && addr == `OFS_RX_STAT && wdata[`STAT_ERR]) begin
            rx_overrun_reg <= 1'b0;
         end
      end
   end

   // Interrupts: ready and error flags gated by their enables
   assign tx_irq = (tx_ready_flag & tx_irq_control[0]) |
                   (tx_underrun_flag & tx_irq_control[1]);
   assign rx_irq = (rx_ready_reg & rx_irq_control[0]) |
                   (rx_overrun_reg & rx_irq_control[1]);  // [RL4]

   // Read data mux; unmapped addresses read as zero
   always @* begin
      rdata_next = 32'h00000000;
      if (cfg_hit) begin
         if (cfg_idx < NONE) begin
            rdata_next = buffer_flat[32*cfg_idx +: 32];  // [RL15]
         end
      end else begin
         case (addr)
            `OFS_SER_MODE:  rdata_next[2*NSER-1:0] = ser_mode_reg;
            `OFS_TX_FMT:    rdata_next[`TX_FMT_W-1:0] = tx_format_reg;
            `OFS_RX_FMT:    rdata_next[`FMT_BUSSEL] = rx_format_reg;
            `OFS_TX_MASK:   rdata_next = tx_mask_reg;
            `OFS_TX_STAT:   rdata_next[1:0] = {tx_underrun_flag, tx_ready_flag};
            `OFS_RX_STAT:   rdata_next[1:0] = {rx_overrun_reg, rx_ready_reg};
            `OFS_TX_IRQCTL: rdata_next[1:0] = tx_irq_control;
            `OFS_RX_IRQCTL: rdata_next[1:0] = rx_irq_control;
            `OFS_DATA_PORT: begin
               if (rx_sel != NONE) begin
                  rdata_next = buffer_flat[32*rx_sel +: 32];  // [RL12]
               end
            end
            default:        rdata_next = 32'h00000000;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (!resetn) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rd_en ? rdata_next : 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// [rtl/audio_port_defs.vh]
// Register offsets, field positions, reset values and codes for the
// audio data service block. Definitions only; included by bare name.
`ifndef AUDIO_PORT_DEFS_VH
`define AUDIO_PORT_DEFS_VH

// Register byte offsets on the 8-bit address port
`define OFS_SER_MODE   8'h00
`define OFS_TX_FMT     8'h04
`define OFS_RX_FMT     8'h08
`define OFS_TX_MASK    8'h0c
`define OFS_TX_STAT    8'h10
`define OFS_RX_STAT    8'h14
`define OFS_TX_IRQCTL  8'h18
`define OFS_RX_IRQCTL  8'h1c
`define OFS_DATA_PORT  8'h20
// Per-serializer buffers: addr[7:6] equals this, index in addr[5:2]
`define SER_BUF_WIN    2'h1

// Serializer modes, two bits per serializer
`define MODE_TX        2'h1
`define MODE_RX        2'h2

// Format register fields
`define FMT_ROT_LSB    0
`define FMT_REV        3
`define FMT_SSZ_LSB    4
`define FMT_BUSSEL     8
`define FMT_PAD_LSB    9
`define FMT_PADBIT_LSB 11
`define FMT_DLY_LSB    16
`define TX_FMT_W       18
`define RESET_TX_FMT   18'h00000
`define RESET_MASK     32'hffffffff

// Pad selections
`define PAD_COPY       2'h0
`define PAD_ZERO       2'h1

// Status bits
`define STAT_READY     0
`define STAT_ERR       1

// Slot length: code n gives 8 + 4n bits, highest legal code 6
`define SSZ_MAX_CODE   3'h6
`define SLOT_BASE_LAST 6'h07
`define SLOT_MAX_LAST  6'h1f

`endif

// [rtl/link_sync.v]
// Two-flop synchroniser for link pins, with rising-edge detection.
// Assumes inputs are asynchronous to clk; rise pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] level,
   output wire [W-1:0] rise
);

   reg [W-1:0] stage1_reg;
   reg [W-1:0] stage2_reg;
   reg [W-1:0] stage3_reg;

   // Stage 1 only feeds stage 2; edges are taken from later stages
   always @(posedge clk) begin
      if (!resetn) begin
         stage1_reg <= {W{1'b0}};
         stage2_reg <= {W{1'b0}};
         stage3_reg <= {W{1'b0}};
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign level = stage2_reg;
   assign rise  = stage2_reg & ~stage3_reg;

endmodule

`default_nettype wire

// [rtl/tx_formatter.v]
// Transmit format unit: mask and pad, then rotate right, then reverse.
// Purely combinational; the caller samples it when a slot loads.
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_defs.vh"

module tx_formatter (
   input  wire [31:0] word,
   input  wire [31:0] mask,
   input  wire [1:0]  pad_mode,
   input  wire [4:0]  pad_bit,
   input  wire [2:0]  rotate,
   input  wire        reverse,
   output reg  [31:0] formatted
);

   reg        pad_value;
   reg [31:0] padded;
   reg [63:0] doubled;
   reg [31:0] rotated;
   integer    k;

   // Mask first on the word as written, then rotate by 4n, then reverse
   always @* begin
      pad_value = 1'b0;
      padded    = 32'h00000000;
      doubled   = 64'h0000000000000000;
      rotated   = 32'h00000000;
      formatted = 32'h00000000;
      case (pad_mode)
         `PAD_COPY: pad_value = word[pad_bit];   // [RL19]
         `PAD_ZERO: pad_value = 1'b0;            // [RL19]
         default:   pad_value = 1'b1;            // [RL19]
      endcase
      padded  = (word & mask) | (~mask & {32{pad_value}});  // [RL20]
      doubled = {padded, padded} >> {rotate, 2'b00};        // [RL17]
      rotated = doubled[31:0];
      for (k = 0; k < 32; k = k + 1) begin
         formatted[k] = reverse ? rotated[31-k] : rotated[k]; // [RL18]
      end
   end

endmodule

`default_nettype wire

// [verification/audio_data_service_properties.sv]
// Port checker for the audio data service block.
// Assumes it is bound to audio_data_service with the same NSER.
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_defs.vh"
module audio_data_service_checker #(
   parameter NSER = 4
) (
   input wire logic            clk,
   input wire logic            resetn,
   input wire logic [7:0]      addr,
   input wire logic [31:0]     wdata,
   input wire logic            wr_en,
   input wire logic            rd_en,
   input wire logic [31:0]     rdata,
   input wire logic            bit_clock,
   input wire logic [NSER-1:0] ser_data_oe,
   input wire logic            tx_dma_request,
   input wire logic            rx_dma_request,
   input wire logic            rx_irq
);
   logic [3:0] rise_age_reg;
   logic       bclk_reg;
   logic [1:0] rx_en_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   function automatic logic [NSER-1:0] tx_modes(input logic [31:0] m);
      for (int i = 0; i < NSER; i++) tx_modes[i] = (m[2*i +: 2] == `MODE_TX);
   endfunction
   // Age of the last bit clock rise, and a copy of the rx irq enables
   always @(posedge clk) begin
      bclk_reg <= bit_clock;
      if (!resetn) rise_age_reg <= 4'hf;
      else if (bit_clock && !bclk_reg) rise_age_reg <= 4'h0;
      else if (rise_age_reg != 4'hf) rise_age_reg <= rise_age_reg + 4'h1;
      if (!resetn) rx_en_reg <= 2'h0;
      else if (wr_en && addr == `OFS_RX_IRQCTL) rx_en_reg <= wdata[1:0];
   end
   a_tx_dma_pulse: assert property (tx_dma_request |=> !tx_dma_request)
      else $error("tx dma request longer than one cycle");
   a_rx_dma_once: assert property (rx_dma_request |=> !rx_dma_request [*8])
      else $error("rx dma request repeated within a slot");
   a_rx_dma_latency: assert property (rx_dma_request |-> rise_age_reg <= 4'h5)
      else $error("rx dma request late after the bit edge");
   a_unmapped_zero: assert property (rd_en && addr[7:6] == 2'h2 |=> rdata == 32'h0)
      else $error("unmapped read returned data");
   a_oe_from_mode: assert property (wr_en && addr == `OFS_SER_MODE
      |=> ser_data_oe == tx_modes($past(wdata))) else $error("output enables wrong");
   a_rx_irq_on: assert property (rx_dma_request && rx_en_reg[0] |-> rx_irq)
      else $error("rx irq missing on ready");
   a_rx_irq_off: assert property (rx_en_reg == 2'h0 |-> !rx_irq)
      else $error("rx irq while disabled");
   a_tx_dma_active: assert property (tx_dma_request |-> |ser_data_oe)
      else $error("tx dma request with no transmitter");
endmodule
bind audio_data_service audio_data_service_checker #(.NSER(NSER)) port_checks (
   .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .bit_clock(bit_clock), .ser_data_oe(ser_data_oe),
   .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request), .rx_irq(rx_irq));
`default_nettype wire

// [verification/audio_data_service_tb_top.sv]
// Bench for the audio data service block: register tasks, data port,
// buffers, status flags and the transmit format on serializer 0.
// Assumes the link source model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_defs.vh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module audio_data_service_tb_top;
   logic        clk = 1'h0;
   logic        resetn = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr_en = 1'h0;
   logic        rd_en = 1'h0;
   logic        run = 1'h0;
   wire  [31:0] rdata;
   wire         bit_clock, frame_sync, tx_dma_request, rx_dma_request, tx_irq, rx_irq;
   wire  [3:0]  ser_data_in, ser_data_out, ser_data_oe;
   int          n_fail = 0, comparisons = 0, cycles = 0;
   logic [31:0] d, e, got;
   logic [31:0] tw [3] = '{32'h123456a5, 32'h80000030, 32'hc3000001};
   logic [31:0] tm [3] = '{32'hffffffff, 32'hffffff0f, 32'hfffffffe};
   logic [1:0]  tp [3] = '{2'h1, 2'h0, 2'h2};
   always #12.5 clk = ~clk;
   audio_data_service #(.NSER(4)) DUT (
      .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .bit_clock(bit_clock), .frame_sync(frame_sync),
      .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
      .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request),
      .tx_irq(tx_irq), .rx_irq(rx_irq));
   link_source #(.NSER(4), .PATTERN(4'h8)) far_end (.run(run), .bit_clock(bit_clock),
      .frame_sync(frame_sync), .ser_data_in(ser_data_in));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'h1;
      @(posedge clk);
      wr_en <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge clk);
      rd_en <= 1'h0;
      #1 d = rdata;
   endtask
   // Sampled on the falling edge, clear of the edge that sets it
   task automatic wait_ev(input bit rx);
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         if (rx ? rx_dma_request : tx_dma_request) break;
      end
      `CHK("dma request", 1'h1, rx ? rx_dma_request : tx_dma_request)
   endtask
   function automatic logic [31:0] fmt(input logic [31:0] w, m, input logic [1:0] pm,
         input logic [2:0] rot, input logic rev);
      logic [31:0] p, x;
      p = (pm == `PAD_COPY) ? {32{w[31]}} : (pm == `PAD_ZERO) ? 32'h0 : 32'hffffffff;
      x = (w & m) | (p & ~m);
      x = 32'({x, x} >> (4 * rot));
      fmt = x;
      if (rev) for (int i = 0; i < 32; i++) fmt[i] = x[31 - i];
   endfunction
   task automatic finish_test;
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Hang guard, far above the run's expected length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         finish_test;
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      rd(`OFS_TX_MASK);
      `CHK("tx mask", `RESET_MASK, d)
      rd(8'h84);
      `CHK("unmapped", 32'h0, d)
      wr(`OFS_SER_MODE, 32'h99);
      wr(`OFS_RX_IRQCTL, 32'h1);
      wr(`OFS_TX_IRQCTL, 32'h2);
      wr(`OFS_TX_FMT, 32'h1 << `FMT_DLY_LSB);
      `CHK("output enables", 4'h5, ser_data_oe)
      run <= 1'h1;
      wait_ev(1'h1);
      `CHK("rx irq", 1'h1, rx_irq)
      rd(`OFS_RX_STAT);
      `CHK("rx ready", 1'h1, d[`STAT_READY])
      rd(`OFS_DATA_PORT);
      `CHK("rx word ser1", 8'h00, d[7:0])
      rd(`OFS_DATA_PORT);
      `CHK("rx word ser3", 8'hff, d[7:0])
      rd(`OFS_DATA_PORT);
      `CHK("past last rx", 32'h0, d)
      rd(`OFS_RX_STAT);
      `CHK("rx ready clear", 1'h0, d[`STAT_READY])
      wr(`OFS_DATA_PORT, 32'ha1);
      wr(`OFS_DATA_PORT, 32'hb2);
      rd(8'h40);
      `CHK("ser0 buffer", 32'ha1, d)
      rd(8'h48);
      `CHK("ser2 buffer", 32'hb2, d)
      rd(`OFS_TX_STAT);
      `CHK("tx ready clear", 1'h0, d[`STAT_READY])
      wait_ev(1'h1);
      wait_ev(1'h1);
      rd(`OFS_RX_STAT);
      `CHK("rx overrun", 1'h1, d[`STAT_ERR])
      rd(`OFS_TX_STAT);
      `CHK("tx underrun", 1'h1, d[`STAT_ERR])
      `CHK("tx irq", 1'h1, tx_irq)
      wr(`OFS_TX_STAT, 32'h2);
      rd(`OFS_TX_STAT);
      `CHK("underrun clear", 1'h0, d[`STAT_ERR])
      wr(`OFS_TX_FMT, 32'h1 << `FMT_BUSSEL);
      wr(8'h48, 32'hc3);
      wr(`OFS_DATA_PORT, 32'hd4);
      rd(8'h48);
      `CHK("ser2 by address", 32'hc3, d)
      rd(8'h40);
      `CHK("ser0 kept", 32'ha1, d)
      // Eight-bit slots; each word is seen on serializer 0 one slot later
      for (int i = 0; i < 3; i++) begin
         e = 32'(i) | (32'(i == 2) << `FMT_REV) | (32'(tp[i]) << `FMT_PAD_LSB);
         wr(`OFS_TX_FMT, e | (32'h1f << `FMT_PADBIT_LSB));
         wr(`OFS_TX_MASK, tm[i]);
         wait_ev(1'h0);
         wr(`OFS_DATA_PORT, tw[i]);
         wait_ev(1'h0);
         for (int b = 0; b < 8; b++) begin
            @(posedge bit_clock);
            got[b] = ser_data_out[0];
         end
         e = fmt(tw[i], tm[i], tp[i], 3'(i), i == 2);
         `CHK("formatted", e[7:0], got[7:0])
      end
      finish_test;
   end
endmodule
`default_nettype wire

// [verification/link_source.sv]
// Far end of the serial link: frame sync, bit clock and receive data.
// Assumes run rises once; the clock then runs free, like the slot counter.
`timescale 1ns/1ps
`default_nettype none
module link_source #(
   parameter NSER = 4,
   parameter logic [NSER-1:0] PATTERN = 4'h0
) (
   input  wire logic            run,
   output var  logic            bit_clock,
   output var  logic            frame_sync,
   output var  logic [NSER-1:0] ser_data_in
);
   // Idle data lines keep moving so a stray sample never looks valid
   initial begin
      bit_clock = 1'h0;
      frame_sync = 1'h0;
      ser_data_in = PATTERN;
      while (!run) #100 ser_data_in = ~ser_data_in;
      frame_sync = 1'h1;
      ser_data_in = PATTERN;
      forever begin
         #100 bit_clock = ~bit_clock;
         if (!bit_clock) frame_sync = 1'h0;
      end
   end
endmodule
`default_nettype wire
